// File: tpw_pkg.sv
// Package: register map, reset values and state records of the PWM timing core
package tpw_pkg;

   // ------------------------------------------------------------
   // Register bus widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // ------------------------------------------------------------
   // Register offsets (word index on the plain register port)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_HALF_PERIOD  = 4'h0;
   localparam logic [3:0] ADDR_DEAD_TIME    = 4'h1;
   localparam logic [3:0] ADDR_PULSE_DEL    = 4'h2;
   localparam logic [3:0] ADDR_SYNC_WIDTH   = 4'h3;
   localparam logic [3:0] ADDR_PHASE_A_DUTY = 4'h4;
   localparam logic [3:0] ADDR_PHASE_B_DUTY = 4'h5;
   localparam logic [3:0] ADDR_PHASE_C_DUTY = 4'h6;
   localparam logic [3:0] ADDR_OUT_SEGMENT  = 4'h7;
   localparam logic [3:0] ADDR_MODE_CTRL    = 4'h8;
   localparam logic [3:0] ADDR_SYS_STATUS   = 4'h9;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MODE_DOUBLE_BIT  = 6;
   localparam int STAT_RUN_BIT     = 0;
   localparam int STAT_HALF_BIT    = 3;
   localparam int SEG_CROSS_LSB    = 6;

   // ------------------------------------------------------------
   // Field widths and reset values
   // ------------------------------------------------------------
   localparam int PERIOD_W = 16;
   localparam int DEAD_W   = 10;
   localparam int SYNCW_W  = 8;
   localparam int SEG_W    = 9;
   localparam int PHASES   = 3;

   localparam logic [7:0]  RST_SYNC_WIDTH = 8'h27;
   localparam logic [15:0] RST_ZERO16     = 16'h0000;
   localparam logic [9:0]  RST_ZERO10     = 10'h000;
   localparam logic [8:0]  RST_SEGMENT    = 9'h03F;

   // ------------------------------------------------------------
   // Timing: one tick is one clock cycle
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS       = 10;
   localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEAD_STEP     = 2;

   // ------------------------------------------------------------
   // State records
   // ------------------------------------------------------------
   typedef struct packed {
      logic                            prev_raw;
      logic [DEAD_W:0]                 dcnt;
      logic                            high;
      logic                            low;
   } tpw_dead_t;

   typedef struct packed {
      logic [PERIOD_W-1:0]             tm_sh;
      logic [DEAD_W-1:0]               dt_sh;
      logic [PERIOD_W-1:0]             pd_sh;
      logic [SYNCW_W-1:0]              sw_sh;
      logic [PHASES-1:0][PERIOD_W-1:0] duty_sh;
      logic [SEG_W-1:0]                seg_sh;
      logic                            mode_dbl;
      logic [3:0]                      written;
      logic                            running;
      logic [PERIOD_W-1:0]             tm_act;
      logic [DEAD_W-1:0]               dt_act;
      logic [PERIOD_W-1:0]             pd_act;
      logic [SYNCW_W-1:0]              sw_act;
      logic [PHASES-1:0][PERIOD_W-1:0] duty_act;
      logic [SEG_W-1:0]                seg_act;
      logic [PERIOD_W-1:0]             cnt;
      logic                            half;
      logic                            sync;
      logic [SYNCW_W-1:0]              sync_cnt;
      logic                            irq;
      logic [DATA_W-1:0]               rdata;
      logic [5:0]                      drive;
   } tpw_core_t;

endpackage

// File: tpw_dead_time.sv
// Dead-time inserter for one complementary output pair
`timescale 1ns/1ps
module tpw_dead_time
(
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   input  wire logic                      run_in,
   input  wire logic                      raw_in,
   input  wire logic [tpw_pkg::DEAD_W-1:0] dead_in,
   output logic                           high_out,
   output logic                           low_out
);

   tpw_pkg::tpw_dead_t st_r;
   tpw_pkg::tpw_dead_t st_nxt;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.prev_raw = raw_in;
      if (!run_in)
      begin
         st_nxt.dcnt = '0;
         st_nxt.high = 1'b0;
         st_nxt.low  = 1'b0;
      end
      else
      begin
         if (raw_in != st_r.prev_raw)
         begin
            st_nxt.dcnt = {dead_in, 1'b0};
         end
         else if (st_r.dcnt != '0)
         begin
            st_nxt.dcnt = st_r.dcnt - 1'b1;
         end
         // Turn-on waits out the delay, turn-off is immediate
         st_nxt.high = raw_in && (st_nxt.dcnt == '0);
         st_nxt.low  = !raw_in && (st_nxt.dcnt == '0);
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign high_out = st_r.high;
   assign low_out  = st_r.low;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_zero_dead;
      @(posedge clk_in) disable iff (rst_in)
      run_in && dead_in == '0 && raw_in && st_r.dcnt == '0 |=> high_out;
   endproperty
   a_zero_dead: assert property (p_zero_dead) else $error("zero dead time delayed");

   property p_dead_hold;
      @(posedge clk_in) disable iff (rst_in)
      run_in && dead_in != '0 && raw_in && !st_r.prev_raw |=> !high_out && !low_out;
   endproperty
   a_dead_hold: assert property (p_dead_hold) else $error("dead time not inserted");

   property p_no_overlap;
      @(posedge clk_in) disable iff (rst_in)
      !(high_out && low_out);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both sides on");

endmodule

// File: tpw_timing_core.sv
// Three-phase centre-based PWM timing core with register port
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module tpw_timing_core
(
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic [tpw_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [tpw_pkg::DATA_W-1:0] reg_wdata_in,
   input  wire logic                       reg_wr_in,
   input  wire logic                       reg_rd_in,
   output logic      [tpw_pkg::DATA_W-1:0] reg_rdata_out,
   output logic                            phase_a_high_drive_out,
   output logic                            phase_a_low_drive_out,
   output logic                            phase_b_high_drive_out,
   output logic                            phase_b_low_drive_out,
   output logic                            phase_c_high_drive_out,
   output logic                            phase_c_low_drive_out,
   output logic                            period_sync_pulse_out,
   output logic                            sync_irq_out,
   output logic                            second_half_out
);

   tpw_pkg::tpw_core_t st_r;
   tpw_pkg::tpw_core_t st_nxt;

   logic [tpw_pkg::PHASES-1:0] raw;
   logic [tpw_pkg::PHASES-1:0] dt_high;
   logic [tpw_pkg::PHASES-1:0] dt_low;

   // ------------------------------------------------------------
   // Centre-based comparison and dead-time stages
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < tpw_pkg::PHASES; g++)
      begin : g_phase
         // High side on while counter is within duty of the centre
         assign raw[g] = ({1'b0, st_r.cnt} + {1'b0, st_r.duty_act[g]})
                         >= {1'b0, st_r.tm_act};

         tpw_dead_time u_dead
         (
            .clk_in   (clk_in),
            .rst_in   (rst_in),
            .run_in   (st_r.running),
            .raw_in   (raw[g]),
            .dead_in  (st_r.dt_act),
            .high_out (dt_high[g]),
            .low_out  (dt_low[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic                         load;
   logic                         start_evt;
   logic                         mid_evt;
   logic [tpw_pkg::PERIOD_W-1:0] tm_m1;
   logic [tpw_pkg::PERIOD_W-1:0] new_tm;
   logic                         sel_hi;
   logic                         sel_lo;

   always_comb
   begin
      st_nxt    = st_r;
      load      = 1'b0;
      start_evt = 1'b0;
      mid_evt   = 1'b0;
      tm_m1     = '0;
      new_tm    = '0;
      sel_hi    = 1'b0;
      sel_lo    = 1'b0;

      // Register writes
      if (reg_wr_in)
      begin
         unique case (reg_addr_in)
            tpw_pkg::ADDR_HALF_PERIOD:
            begin
               st_nxt.tm_sh      = reg_wdata_in;
               st_nxt.written[0] = 1'b1;
            end
            tpw_pkg::ADDR_DEAD_TIME:
            begin
               st_nxt.dt_sh = reg_wdata_in[tpw_pkg::DEAD_W-1:0];
            end
            tpw_pkg::ADDR_PULSE_DEL:
            begin
               st_nxt.pd_sh = reg_wdata_in;
            end
            tpw_pkg::ADDR_SYNC_WIDTH:
            begin
               st_nxt.sw_sh = reg_wdata_in[tpw_pkg::SYNCW_W-1:0];
            end
            tpw_pkg::ADDR_PHASE_A_DUTY:
            begin
               st_nxt.duty_sh[0] = reg_wdata_in;
               st_nxt.written[1] = 1'b1;
            end
            tpw_pkg::ADDR_PHASE_B_DUTY:
            begin
               st_nxt.duty_sh[1] = reg_wdata_in;
               st_nxt.written[2] = 1'b1;
            end
            tpw_pkg::ADDR_PHASE_C_DUTY:
            begin
               st_nxt.duty_sh[2] = reg_wdata_in;
               st_nxt.written[3] = 1'b1;
            end
            tpw_pkg::ADDR_OUT_SEGMENT:
            begin
               st_nxt.seg_sh = reg_wdata_in[tpw_pkg::SEG_W-1:0];
            end
            tpw_pkg::ADDR_MODE_CTRL:
            begin
               st_nxt.mode_dbl = reg_wdata_in[tpw_pkg::MODE_DOUBLE_BIT];
            end
            default:
            begin
            end
         endcase
      end

      // Register reads, answered in the next cycle
      st_nxt.rdata = '0;
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            tpw_pkg::ADDR_HALF_PERIOD:  st_nxt.rdata = st_r.tm_sh;
            tpw_pkg::ADDR_DEAD_TIME:    st_nxt.rdata = {6'h00, st_r.dt_sh};
            tpw_pkg::ADDR_PULSE_DEL:    st_nxt.rdata = st_r.pd_sh;
            tpw_pkg::ADDR_SYNC_WIDTH:   st_nxt.rdata = {8'h00, st_r.sw_sh};
            tpw_pkg::ADDR_PHASE_A_DUTY: st_nxt.rdata = st_r.duty_sh[0];
            tpw_pkg::ADDR_PHASE_B_DUTY: st_nxt.rdata = st_r.duty_sh[1];
            tpw_pkg::ADDR_PHASE_C_DUTY: st_nxt.rdata = st_r.duty_sh[2];
            tpw_pkg::ADDR_OUT_SEGMENT:  st_nxt.rdata = {7'h00, st_r.seg_sh};
            tpw_pkg::ADDR_MODE_CTRL:
            begin
               st_nxt.rdata[tpw_pkg::MODE_DOUBLE_BIT] = st_r.mode_dbl;
            end
            tpw_pkg::ADDR_SYS_STATUS:
            begin
               st_nxt.rdata[tpw_pkg::STAT_HALF_BIT] = st_r.half;
               st_nxt.rdata[tpw_pkg::STAT_RUN_BIT]  = st_r.running;
            end
            default:
            begin
               st_nxt.rdata = '0;
            end
         endcase
      end

      // Timer start once period and all duties are written
      if (!st_r.running)
      begin
         if (&st_r.written)
         begin
            st_nxt.running = 1'b1;
            start_evt      = 1'b1;
            load           = 1'b1;
         end
      end
      else if (!st_r.half)
      begin
         // Rising half: count up to one below the half-period value
         tm_m1 = st_r.tm_act - 1'b1;
         if (st_r.cnt >= tm_m1 || st_r.tm_act == '0)
         begin
            st_nxt.half = 1'b1;
            mid_evt     = 1'b1;
            load        = st_r.mode_dbl;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt + 1'b1;
         end
      end
      else
      begin
         // Falling half: count back down to zero
         if (st_r.cnt == '0)
         begin
            st_nxt.half = 1'b0;
            start_evt   = 1'b1;
            load        = 1'b1;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt - 1'b1;
         end
      end

      // Shadow to active transfer on each sync rising edge
      if (load)
      begin
         st_nxt.tm_act   = st_nxt.tm_sh;
         st_nxt.dt_act   = st_nxt.dt_sh;
         st_nxt.pd_act   = st_nxt.pd_sh;
         st_nxt.sw_act   = st_nxt.sw_sh;
         st_nxt.duty_act = st_nxt.duty_sh;
         st_nxt.seg_act  = st_nxt.seg_sh;
         st_nxt.sync     = 1'b1;
         st_nxt.sync_cnt = st_nxt.sw_sh;
         st_nxt.irq      = 1'b1;
         new_tm          = st_nxt.tm_sh;
         if (start_evt)
         begin
            st_nxt.cnt = '0;
         end
         else if (mid_evt && new_tm != '0)
         begin
            st_nxt.cnt = new_tm - 1'b1;
         end
         else
         begin
            st_nxt.cnt = '0;
         end
      end
      else
      begin
         st_nxt.irq = 1'b0;
         if (st_r.sync)
         begin
            if (st_r.sync_cnt != '0)
            begin
               st_nxt.sync_cnt = st_r.sync_cnt - 1'b1;
            end
            else
            begin
               st_nxt.sync = 1'b0;
            end
         end
      end

      // Output steering: crossover and per-output enable
      for (int p = 0; p < tpw_pkg::PHASES; p++)
      begin
         if (st_r.seg_act[tpw_pkg::SEG_CROSS_LSB + p])
         begin
            sel_hi = dt_low[p];
            sel_lo = dt_high[p];
         end
         else
         begin
            sel_hi = dt_high[p];
            sel_lo = dt_low[p];
         end
         st_nxt.drive[2*p]   = st_r.running && st_r.seg_act[2*p] && sel_hi;
         st_nxt.drive[2*p+1] = st_r.running && st_r.seg_act[2*p+1] && sel_lo;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_r          <= '0;
         st_r.sw_sh    <= tpw_pkg::RST_SYNC_WIDTH;
         st_r.sw_act   <= tpw_pkg::RST_SYNC_WIDTH;
         st_r.seg_sh   <= tpw_pkg::RST_SEGMENT;
         st_r.seg_act  <= tpw_pkg::RST_SEGMENT;
         st_r.mode_dbl <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata_out          = st_r.rdata;
   assign phase_a_high_drive_out = st_r.drive[0];
   assign phase_a_low_drive_out  = st_r.drive[1];
   assign phase_b_high_drive_out = st_r.drive[2];
   assign phase_b_low_drive_out  = st_r.drive[3];
   assign phase_c_high_drive_out = st_r.drive[4];
   assign phase_c_low_drive_out  = st_r.drive[5];
   assign period_sync_pulse_out  = st_r.sync;
   assign sync_irq_out           = st_r.irq;
   assign second_half_out        = st_r.half;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_sync_hold;
      @(posedge clk_in) disable iff (rst_in)
      period_sync_pulse_out && st_r.sync_cnt != '0 && !load |=> period_sync_pulse_out;
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync pulse ended early");

   property p_sync_end;
      @(posedge clk_in) disable iff (rst_in)
      period_sync_pulse_out && st_r.sync_cnt == '0 && !load |=> !period_sync_pulse_out;
   endproperty
   a_sync_end: assert property (p_sync_end) else $error("sync pulse too long");

   property p_mode_reset;
      @(posedge clk_in)
      rst_in |=> !st_r.mode_dbl && st_r.sw_sh == tpw_pkg::RST_SYNC_WIDTH;
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("reset values wrong");

   property p_single_sync;
      @(posedge clk_in) disable iff (rst_in)
      $rose(st_r.half) && !$past(st_r.mode_dbl) |-> !st_r.irq;
   endproperty
   a_single_sync: assert property (p_single_sync) else $error("midpoint sync in single");

   property p_double_mid;
      @(posedge clk_in) disable iff (rst_in)
      $rose(st_r.half) && $past(st_r.mode_dbl) |-> st_r.irq && period_sync_pulse_out;
   endproperty
   a_double_mid: assert property (p_double_mid) else $error("midpoint sync missing");

   property p_irq_sync;
      @(posedge clk_in) disable iff (rst_in)
      sync_irq_out |-> period_sync_pulse_out && st_r.sync_cnt == st_r.sw_act;
   endproperty
   a_irq_sync: assert property (p_irq_sync) else $error("irq without sync");

   property p_idle_quiet;
      @(posedge clk_in) disable iff (rst_in)
      !st_r.running |-> st_r.drive == '0 && !period_sync_pulse_out;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("output before start");

   property p_cnt_range;
      @(posedge clk_in) disable iff (rst_in)
      st_r.running && st_r.tm_act != '0 |-> st_r.cnt < st_r.tm_act;
   endproperty
   a_cnt_range: assert property (p_cnt_range) else $error("counter past half period");

endmodule

// File: tpw_gate_model.sv
// Gate driver and converter model of the PWM timing core
`timescale 1ns/1ps
module tpw_gate_model
(
   input  wire logic        clk_in,
   input  wire logic [5:0]  drive_in,
   input  wire logic        sync_in,
   output logic      [15:0] shoot_cnt_out,
   output logic      [15:0] sync_cnt_out
);
   logic sync_r;
   logic shoot;

   initial
   begin
      shoot_cnt_out = 16'h0000;
      sync_cnt_out  = 16'h0000;
      sync_r        = 1'b0;
   end

   // Both switches of one leg on
   assign shoot = (drive_in[0] & drive_in[1]) | (drive_in[2] & drive_in[3])
                | (drive_in[4] & drive_in[5]);

   always @(posedge clk_in)
   begin
      if (shoot)
         shoot_cnt_out <= shoot_cnt_out + 16'h0001;
      if (sync_in & !sync_r)
         sync_cnt_out <= sync_cnt_out + 16'h0001;
      sync_r <= sync_in;
   end
endmodule

// File: tpw_timing_core_bench.sv
// Self-checking bench of the PWM timing core
`timescale 1ns/1ps
module tpw_timing_core_bench;
   localparam int TM = 40;
   logic        clk_in    = 1'b0;
   logic        rst_in    = 1'b1;
   logic [3:0]  addr      = 4'h0;
   logic [15:0] wdata     = 16'h0000;
   logic        wr        = 1'b0;
   logic        rd        = 1'b0;
   logic [15:0] rdata;
   wire  [8:0]  obs;
   logic [15:0] shoot_cnt;
   logic [15:0] sync_cnt;
   logic [31:0] seed_r    = 32'hCA44;
   logic [15:0] v;
   int          err_count = 0;
   int          n_tests   = 0;
   int          hi;
   int          lo;
   int          dt;
   int          sw;
   int          d[3];

   always #5 clk_in = ~clk_in;

   tpw_timing_core DUT
   (
      .clk_in                 (clk_in),
      .rst_in                 (rst_in),
      .reg_addr_in            (addr),
      .reg_wdata_in           (wdata),
      .reg_wr_in              (wr),
      .reg_rd_in              (rd),
      .reg_rdata_out          (rdata),
      .phase_a_high_drive_out (obs[0]),
      .phase_a_low_drive_out  (obs[1]),
      .phase_b_high_drive_out (obs[2]),
      .phase_b_low_drive_out  (obs[3]),
      .phase_c_high_drive_out (obs[4]),
      .phase_c_low_drive_out  (obs[5]),
      .period_sync_pulse_out  (obs[6]),
      .sync_irq_out           (obs[7]),
      .second_half_out        (obs[8])
   );

   tpw_gate_model GATES
   (
      .clk_in        (clk_in),
      .drive_in      (obs[5:0]),
      .sync_in       (obs[6]),
      .shoot_cnt_out (shoot_cnt),
      .sync_cnt_out  (sync_cnt)
   );

   function automatic int rnd(input int m);
      seed_r = {seed_r[30:0], seed_r[31] ^ seed_r[21] ^ seed_r[1] ^ seed_r[0]};
      return int'(seed_r[15:0]) % m;
   endfunction

   function automatic logic [15:0] rst_val(input int a);
      return (a == 3) ? 16'h0027 : ((a == 7) ? 16'h003F : 16'h0000);
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] dv);
      @(posedge clk_in);
      addr  <= a;
      wdata <= dv;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [15:0] dv);
      @(posedge clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_in);
      rd   <= 1'b0;
      #1;
      dv = rdata;
   endtask

   // Cycles for which one output keeps a level
   task automatic hold(input int i, input logic val, output int c);
      c = 0;
      while (obs[i] === val && c < 3000)
      begin
         @(negedge clk_in);
         c++;
      end
   endtask

   task automatic meas(input int i, output int h, output int l);
      int t;
      @(negedge clk_in);
      hold(i, 1'b1, t);
      hold(i, 1'b0, t);
      hold(i, 1'b1, h);
      hold(i, 1'b0, l);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #500000;
      err_count++;
      report_and_stop();
   end

   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int a = 0; a < 11; a++)
      begin
         rd_reg(4'(a), v);
         check(v, rst_val(a));
      end
      wr_reg(tpw_pkg::ADDR_DEAD_TIME, 16'hFFFF);
      wr_reg(tpw_pkg::ADDR_HALF_PERIOD, 16'hFFFF);
      wr_reg(tpw_pkg::ADDR_SYS_STATUS, 16'hFFFF);
      rd_reg(tpw_pkg::ADDR_DEAD_TIME, v);
      check(v, 16'h03FF);
      rd_reg(tpw_pkg::ADDR_HALF_PERIOD, v);
      check(v, 16'hFFFF);
      rd_reg(tpw_pkg::ADDR_SYS_STATUS, v);
      check(v, 16'h0000);
      $display("register test done");
      wr_reg(tpw_pkg::ADDR_HALF_PERIOD, 16'(TM));
      wr_reg(tpw_pkg::ADDR_PHASE_A_DUTY, 16'h000A);
      wr_reg(tpw_pkg::ADDR_PHASE_B_DUTY, 16'h0014);
      repeat (100) @(posedge clk_in);
      check({7'h00, obs}, 16'h0000);
      for (int k = 0; k < 4; k++)
      begin
         dt = (k == 0) ? 0 : 1 + rnd(6);
         sw = (k == 1) ? 0 : rnd(20);
         wr_reg(tpw_pkg::ADDR_DEAD_TIME, 16'(dt));
         wr_reg(tpw_pkg::ADDR_SYNC_WIDTH, 16'(sw));
         for (int p = 0; p < 3; p++)
         begin
            d[p] = dt + 1 + rnd(TM - 2 * dt - 2);
            wr_reg(4'(4 + p), 16'(d[p]));
         end
         meas(6, hi, lo);
         meas(6, hi, lo);
         check(16'(hi), 16'(sw + 1));
         check(16'(hi + lo), 16'(2 * TM));
         for (int p = 0; p < 3; p++)
         begin
            meas(2 * p, hi, lo);
            check(16'(hi), 16'(2 * (d[p] - dt)));
            meas(2 * p + 1, hi, lo);
            check(16'(hi), 16'(2 * (TM - d[p] - dt)));
         end
         $display("random pass %0d done", k);
      end
      meas(7, hi, lo);
      check(16'(hi), 16'h0001);
      check(16'(hi + lo), 16'(2 * TM));
      wr_reg(tpw_pkg::ADDR_OUT_SEGMENT, 16'h007F);
      meas(6, hi, lo);
      meas(0, hi, lo);
      check(16'(hi), 16'(2 * (TM - d[0] - dt)));
      wr_reg(tpw_pkg::ADDR_OUT_SEGMENT, 16'h003F);
      $display("crossover test done");
      wr_reg(tpw_pkg::ADDR_MODE_CTRL, 16'h0040);
      rd_reg(tpw_pkg::ADDR_MODE_CTRL, v);
      check(v, 16'h0040);
      meas(6, hi, lo);
      meas(6, hi, lo);
      check(16'(hi + lo), 16'(TM));
      meas(8, hi, lo);
      check(16'(hi), 16'(TM));
      rd_reg(tpw_pkg::ADDR_SYS_STATUS, v);
      check({15'h0000, v[3]}, 16'h0001);
      hold(8, 1'b1, hi);
      rd_reg(tpw_pkg::ADDR_SYS_STATUS, v);
      check({15'h0000, v[3]}, 16'h0000);
      for (int s = 0; s < 4; s++)
      begin
         hold(7, 1'b0, hi);
         wr_reg(tpw_pkg::ADDR_PHASE_A_DUTY, 16'(TM / 2));
      end
      meas(0, hi, lo);
      check(16'(hi), 16'(2 * (TM / 2 - dt)));
      $display("double update test done");
      check(shoot_cnt, 16'h0000);
      check({15'h0000, sync_cnt != 16'h0000}, 16'h0001);
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rd_reg(tpw_pkg::ADDR_MODE_CTRL, v);
      check(v, 16'h0000);
      check({7'h00, obs}, 16'h0000);
      $display("second reset test done");
      report_and_stop();
   end
endmodule
